//--- hw/rail_enable_map.vh
// Purpose: register offsets, field positions and reset values of the rail enable registers
// Assumes: 8-bit subaddress and data as seen from the internal register port
// Notes: included by the rail enable block; the bench uses literal addresses and masks
`ifndef RAIL_ENABLE_MAP_VH
`define RAIL_ENABLE_MAP_VH

// subaddresses
`define CONV_EN_ADDR 8'h11
`define REG_SW_ADDR 8'h12
`define PIN_FUNC_ADDR 8'h13
`define WARM_RST_ADDR 8'h14

// reset values
`define CONV_EN_RESET 8'h00
`define REG_SW_RESET 8'h00

// converter_enable_control fields
`define BUCK_ONE_BIT 0
`define BUCK_TWO_BIT 1
`define BUCK_THREE_BIT 2
`define BUCK_BOOST_FOUR_BIT 3
`define CONV_EN_RW_MASK 8'h3F

// regulator_switch_output_control fields
`define LINEAR_REG_BIT 0
`define LOAD_SWITCH_BIT 3
`define GP_OUT_ONE_BIT 4
`define GP_PIN_TWO_BIT 6
`define REG_SW_RW_MASK 8'h7F

`endif

//--- hw/rail_enable_field.v
// Purpose: one write-maskable 8-bit register with sequencer override of selected bits
// Assumes: write strobe and sequencer strobe from the same clock domain
// Notes: on the SEQ_MASK bits the sequencer takes priority over a software write in the same cycle
`timescale 1ns/1ps

module rail_enable_field #(
    parameter [7:0] RESET_VAL = 8'h00,
    parameter [7:0] RW_MASK = 8'hFF,
    parameter [7:0] SEQ_MASK = 8'h00
) (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // software write
    input wire wr_en_in,
    input wire [7:0] wr_data_in,
    // sequencer override
    input wire seq_en_in,
    input wire [7:0] seq_data_in,
    // value
    output reg [7:0] value_out
);

    wire [7:0] sw_val;
    wire [7:0] value_nxt;

    // read-only bits keep zero, read/write bits take the write
    assign sw_val = wr_en_in ? (wr_data_in & RW_MASK) : value_out;
    assign value_nxt = seq_en_in ? ((sw_val & ~SEQ_MASK) | (seq_data_in & SEQ_MASK)) : sw_val;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            value_out <= RESET_VAL;
        end else begin
            value_out <= value_nxt;
        end
    end

endmodule

//--- hw/rail_enable_registers.v
// Purpose: converter, regulator, load switch and general-purpose pin enable registers
// Assumes: register port already decoded from the serial control port, unlock decided upstream
// Notes: sequencer updates arrive as a one-cycle strobe with the rail decisions
// Function
// - first enable register at 0x11, protected
// - bit 3 turns converter four on
// - bit 2 turns converter three on
// - bit 1 turns converter two on
// - bit 0 turns converter one on
// - sequencer overwrites converter bits during sequencing
// - second enable register at 0x12, protected
// - bit 6 drives pin two low or releases
// - warm-reset select makes pin two bit ignored
// - bit 4 drives output one low or releases
// - pin-function select makes output one bit ignored
// - bit 3 turns load switch on
// - bit 0 linear regulator, sequencer also updates
// - warm-reset select makes pin two an input
`timescale 1ns/1ps
`include "rail_enable_map.vh"

module rail_enable_registers (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // register port
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_rd_in,
    input wire unlocked_in,
    output reg [7:0] reg_rdata_out,
    // sequencer
    input wire seq_update_in,
    input wire [3:0] seq_buck_on_in,
    input wire seq_linear_reg_on_in,
    // pin function selects
    input wire warm_reset_pin_select_in,
    input wire gp_output_one_pin_select_in,
    // general-purpose pin two
    input wire gp_pin_two_in,
    output reg gp_pin_two_oe_out,
    output reg gp_pin_two_o_out,
    output reg warm_reset_out,
    // general-purpose output one
    output reg gp_output_one_pin_oe_out,
    output reg gp_output_one_pin_o_out,
    // rail enables
    output reg buck_one_on_out,
    output reg buck_two_on_out,
    output reg buck_three_on_out,
    output reg buck_boost_four_on_out,
    output reg linear_reg_on_out,
    output reg load_switch_on_out
);

    wire [7:0] conv_en_val;
    wire [7:0] reg_sw_val;
    wire conv_wr;
    wire reg_sw_wr;
    wire [7:0] seq_conv_data;
    wire [7:0] seq_reg_data;
    reg pin_two_meta_r;
    reg pin_two_sync_r;

    function addr_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // protected writes only take effect when unlocked
    assign conv_wr = reg_wr_in & unlocked_in & addr_hit(reg_addr_in, `CONV_EN_ADDR);
    assign reg_sw_wr = reg_wr_in & unlocked_in & addr_hit(reg_addr_in, `REG_SW_ADDR);

    assign seq_conv_data = {4'h0, seq_buck_on_in};
    assign seq_reg_data = {7'h00, seq_linear_reg_on_in};

    // bits 7:6 read-only zero, bits 5:4 hold, bits 3:0 converters
    rail_enable_field #(
        .RESET_VAL(`CONV_EN_RESET),
        .RW_MASK(`CONV_EN_RW_MASK),
        .SEQ_MASK(8'h0F)
    ) u_conv_en (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_en_in(conv_wr),
        .wr_data_in(reg_wdata_in),
        .seq_en_in(seq_update_in),
        .seq_data_in(seq_conv_data),
        .value_out(conv_en_val)
    );

    // bit 7 read-only zero, others hold, bit 0 sequencer-updated
    rail_enable_field #(
        .RESET_VAL(`REG_SW_RESET),
        .RW_MASK(`REG_SW_RW_MASK),
        .SEQ_MASK(8'h01)
    ) u_reg_sw (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_en_in(reg_sw_wr),
        .wr_data_in(reg_wdata_in),
        .seq_en_in(seq_update_in),
        .seq_data_in(seq_reg_data),
        .value_out(reg_sw_val)
    );

    // pin two input synchroniser
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_two_meta_r <= 1'b0;
            pin_two_sync_r <= 1'b0;
        end else begin
            pin_two_meta_r <= gp_pin_two_in;
            pin_two_sync_r <= pin_two_meta_r;
        end
    end

    // registered outputs
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
            buck_one_on_out <= 1'b0;
            buck_two_on_out <= 1'b0;
            buck_three_on_out <= 1'b0;
            buck_boost_four_on_out <= 1'b0;
            linear_reg_on_out <= 1'b0;
            load_switch_on_out <= 1'b0;
            gp_pin_two_oe_out <= 1'b0;
            gp_pin_two_o_out <= 1'b0;
            warm_reset_out <= 1'b0;
            gp_output_one_pin_oe_out <= 1'b0;
            gp_output_one_pin_o_out <= 1'b0;
        end else begin
            if (reg_rd_in) begin
                if (addr_hit(reg_addr_in, `CONV_EN_ADDR)) begin
                    reg_rdata_out <= conv_en_val;
                end else if (addr_hit(reg_addr_in, `REG_SW_ADDR)) begin
                    reg_rdata_out <= reg_sw_val;
                end else begin
                    reg_rdata_out <= 8'h00;
                end
            end
            buck_one_on_out <= conv_en_val[`BUCK_ONE_BIT];
            buck_two_on_out <= conv_en_val[`BUCK_TWO_BIT];
            buck_three_on_out <= conv_en_val[`BUCK_THREE_BIT];
            buck_boost_four_on_out <= conv_en_val[`BUCK_BOOST_FOUR_BIT];
            linear_reg_on_out <= reg_sw_val[`LINEAR_REG_BIT];
            load_switch_on_out <= reg_sw_val[`LOAD_SWITCH_BIT];
            // open drain: 0 drives low, 1 releases
            gp_pin_two_o_out <= 1'b0;
            gp_pin_two_oe_out <= ~warm_reset_pin_select_in & ~reg_sw_val[`GP_PIN_TWO_BIT];
            // low level on pin two requests warm reset of converters one and two
            warm_reset_out <= warm_reset_pin_select_in & ~pin_two_sync_r;
            gp_output_one_pin_o_out <= 1'b0;
            gp_output_one_pin_oe_out <= ~gp_output_one_pin_select_in & ~reg_sw_val[`GP_OUT_ONE_BIT];
        end
    end

endmodule

//--- tb/rail_enable_checker_assertions.sv
// Purpose: port checks of the rail enable registers
// Assumes: outputs follow a register update one edge later
// Notes: bound to the design at the foot of this file
`timescale 1ns/1ps
module rail_enable_checker (
    input wire clk_in, rst_in, reg_wr_in, reg_rd_in, unlocked_in, seq_update_in, seq_linear_reg_on_in,
    input wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
    input wire [3:0] seq_buck_on_in,
    input wire warm_reset_pin_select_in, gp_output_one_pin_select_in, gp_pin_two_oe_out,
    input wire gp_output_one_pin_oe_out, linear_reg_on_out, load_switch_on_out,
    input wire buck_one_on_out, buck_two_on_out, buck_three_on_out, buck_boost_four_on_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_wr11;
        reg_wr_in && unlocked_in && reg_addr_in == 8'h11 && !seq_update_in;
    endsequence
    sequence s_rd11;
        reg_rd_in && !reg_wr_in && reg_addr_in == 8'h11 && !seq_update_in;
    endsequence
    a_buck_one_write:
    assert property (s_wr11 |-> ##2 buck_one_on_out == $past(reg_wdata_in[0], 2)) else $error("buck one");
    a_conv_readback:
    assert property (s_wr11 ##3 s_rd11 |=> reg_rdata_out == ($past(reg_wdata_in, 4) & 8'h3F)) else $error("readback");
    a_seq_wins:
    assert property (seq_update_in |-> ##2 {buck_boost_four_on_out, buck_three_on_out, buck_two_on_out,
        buck_one_on_out, linear_reg_on_out} == {$past(seq_buck_on_in, 2), $past(seq_linear_reg_on_in, 2)})
        else $error("sequencer");
    a_load_sw_write:
    assert property (reg_wr_in && unlocked_in && reg_addr_in == 8'h12 |-> ##2
        load_switch_on_out == $past(reg_wdata_in[3], 2)) else $error("load switch");
    a_load_sw_hold:
    assert property (!(reg_wr_in && unlocked_in && reg_addr_in == 8'h12) |-> ##2 $stable(load_switch_on_out))
        else $error("load switch moved");
    a_pin_two_sel:
    assert property (warm_reset_pin_select_in |=> !gp_pin_two_oe_out) else $error("pin two driven");
    a_out_one_sel:
    assert property (gp_output_one_pin_select_in |=> !gp_output_one_pin_oe_out) else $error("output one driven");
    a_ro_bits_zero:
    assert property (reg_rd_in && reg_addr_in == 8'h11 |=> reg_rdata_out[7:6] == 2'h0) else $error("ro bits");
endmodule
bind rail_enable_registers rail_enable_checker u_rail_enable_checker (.*);

//--- tb/host_ctrl_model.sv
// Purpose: host side of the register port
// Assumes: caller enters tasks at a falling edge
// Notes: released data bus shows the inverse of the last byte
`timescale 1ns/1ps
module host_ctrl_model (
    input wire clk_in,
    input wire [7:0] rdata_in,
    output logic [7:0] addr_out = 8'h00,
    output logic [7:0] wdata_out = 8'h00,
    output logic wr_out = 1'b0,
    output logic rd_out = 1'b0,
    output logic unlock_out = 1'b0
);
    task wr(input logic [7:0] a, input logic [7:0] d, input logic u);
        addr_out = a;
        wdata_out = d;
        unlock_out = u;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        unlock_out = 1'b0;
        wdata_out = ~d;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        d = rdata_in;
    endtask
endmodule

//--- tb/testbench.sv
// Purpose: register sequences against the rail enable block
// Assumes: inputs change at the falling edge
// Notes: pin two has a pull-up and an external pull-down switch
`timescale 1ns/1ps
module testbench;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic seq_update_in = 1'b0;
    logic [3:0] seq_buck_on_in = 4'hA;
    logic seq_linear_reg_on_in = 1'b1;
    logic warm_reset_pin_select_in = 1'b0;
    logic gp_output_one_pin_select_in = 1'b0;
    logic ext_low = 1'b0;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, d;
    logic reg_wr_in, reg_rd_in, unlocked_in, gp_pin_two_oe_out, warm_reset_out, gp_output_one_pin_oe_out;
    logic buck_one_on_out, buck_two_on_out, buck_three_on_out, buck_boost_four_on_out;
    logic linear_reg_on_out, load_switch_on_out;
    logic gp_pin_two_o_out, gp_output_one_pin_o_out;
    int n_errors = 0;
    int num_checks = 0;
    wire gp_pin_two_in = !(gp_pin_two_oe_out || ext_low);
    always #20 clk_in = ~clk_in;
    rail_enable_registers u_rail_enable_registers (.*);
    host_ctrl_model u_host_ctrl_model (.clk_in(clk_in), .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
        .wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in), .unlock_out(unlocked_in));
    task chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
        u_host_ctrl_model.rd(a, d);
        chk(d, e);
        @(negedge clk_in);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v, input logic u);
        u_host_ctrl_model.wr(a, v, u);
        repeat (2) @(negedge clk_in);
    endtask
    task close_out;
        if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        close_out;
    end
    initial begin
        repeat (20) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rdc(8'h11, 8'h00);
        rdc(8'h12, 8'h00);
        chk({gp_pin_two_oe_out, gp_output_one_pin_oe_out}, 8'h03);
        chk({gp_pin_two_o_out, gp_output_one_pin_o_out}, 8'h00);
        wr(8'h11, 8'hFF, 1'b1);
        rdc(8'h11, 8'h3F);
        chk({buck_boost_four_on_out, buck_three_on_out, buck_two_on_out, buck_one_on_out}, 8'h0F);
        wr(8'h11, 8'h00, 1'b0);
        rdc(8'h11, 8'h3F);
        wr(8'h12, 8'hFF, 1'b1);
        rdc(8'h12, 8'h7F);
        chk({gp_pin_two_oe_out, gp_output_one_pin_oe_out, load_switch_on_out, linear_reg_on_out}, 8'h03);
        wr(8'h12, 8'h00, 1'b1);
        warm_reset_pin_select_in = 1'b1;
        gp_output_one_pin_select_in = 1'b1;
        ext_low = 1'b1;
        repeat (4) @(negedge clk_in);
        chk({gp_pin_two_oe_out, gp_output_one_pin_oe_out, warm_reset_out}, 8'h01);
        fork
            wr(8'h11, 8'h35, 1'b1);
            begin
                seq_update_in = 1'b1;
                @(negedge clk_in);
                seq_update_in = 1'b0;
            end
        join
        rdc(8'h11, 8'h3A);
        rdc(8'h12, 8'h01);
        chk({buck_boost_four_on_out, buck_three_on_out, buck_two_on_out, buck_one_on_out}, 8'h0A);
        chk({7'h00, linear_reg_on_out}, 8'h01);
        rdc(8'h13, 8'h00);
        ext_low = 1'b0;
        repeat (4) @(negedge clk_in);
        chk({7'h00, warm_reset_out}, 8'h00);
        close_out;
    end
endmodule
